/* File: hw/bct_master.sv */
// Purpose: Bus master ending cycles on acknowledge, bus error or retry
// Assumes: Strobes and response lines are active low open lines
// Notes:   One cycle per START write; polls on APB status
// How it works
// - without retry support, only acknowledge or bus error ends the cycle
// - retry-capable master ends cycle on retry low without waiting
// - after retry the master releases the bus to pending requests
// - re-request after retry waits a programmable delay if others pend
// - address strobe falls before data strobes; one response ends it
// - data strobes and write data wait for acknowledge and error high
// - on response the master raises all strobes; slave then releases
`timescale 1ns/1ps
`default_nettype none
module bct_master
	import bct_pkg::*;
#(
	parameter int AW = 24
) (
	input  wire logic          pclk,         // clock
	input  wire logic          presetn,      // async reset, low
	input  wire logic          psel,         // APB select
	input  wire logic          penable,      // APB enable
	input  wire logic          pwrite,       // APB direction
	input  wire logic [7:0]    paddr,        // APB address
	input  wire logic [31:0]   pwdata,       // APB write data
	output logic      [31:0]   prdata,       // APB read data
	output logic               pready,       // APB ready
	output logic               pslverr,      // APB error
	output logic      [AW-1:0] bus_addr,     // address lines
	output logic               as_n,         // address strobe
	output logic               ds_n,         // data strobe
	output logic               write_n,      // low for write
	input  wire logic [7:0]    data_in,      // data lines in
	output logic      [7:0]    data_out,     // data lines out
	output logic               data_oe,      // data drive enable
	input  wire logic          dtack_n,      // acknowledge pin
	input  wire logic          berr_n,       // bus error pin
	input  wire logic          retry_n,      // retry pin
	input  wire logic          other_req,    // another request pending
	output logic               bus_busy      // holding bus mastership
);
	bct_state_t state_reg, state_next;
	logic [AW-1:0] addr_reg;
	logic [7:0]    wdata_reg, rdata_reg;
	logic [2:0]    ctrl_reg;
	logic [5:0]    status_reg, status_next;
	logic [15:0]   delay_reg, cnt_reg, cnt_next;
	logic          dtack_s, berr_s, retry_s;
	logic [7:0]    data_s;
	// Data pins cross domains too; same lag as dtack so latch stays aligned
	bct_sync #(.W(8)) u_dsync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (data_in),
		.rst_val (8'hFF),
		.q       (data_s)
	);
	bct_sync #(.W(3)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({dtack_n, berr_n, retry_n}),
		.rst_val (3'h7),
		.q       ({dtack_s, berr_s, retry_s})
	);
	wire wr_acc    = psel && penable && pwrite;
	wire start_w   = wr_acc && paddr == BCT_CTRL_OFS && pwdata[BCT_CTRL_START]
		&& state_reg == BCT_IDLE;
	wire resp_idle = dtack_s && berr_s;
	wire retry_hit = ctrl_reg[BCT_CTRL_RTYEN] && !retry_s;
	wire ack_hit   = !dtack_s && berr_s;
	wire berr_hit  = !berr_s;
	wire resp_any  = ack_hit || berr_hit || retry_hit;
	wire is_wr     = ctrl_reg[BCT_CTRL_WRITE];
	wire sig_ok    = rdata_reg == BCT_ROM_SIG_VAL;
	wire map_hit   = paddr == BCT_CTRL_OFS || paddr == BCT_ADDR_OFS
		|| paddr == BCT_WDATA_OFS || paddr == BCT_RDATA_OFS
		|| paddr == BCT_STATUS_OFS || paddr == BCT_DELAY_OFS;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !map_hit;
	always_comb begin
		case (paddr)
			BCT_CTRL_OFS:   prdata = {29'h0, ctrl_reg};
			BCT_ADDR_OFS:   prdata = 32'(addr_reg);
			BCT_WDATA_OFS:  prdata = {24'h0, wdata_reg};
			BCT_RDATA_OFS:  prdata = {24'h0, rdata_reg};
			BCT_STATUS_OFS: prdata = {26'h0, status_reg};
			BCT_DELAY_OFS:  prdata = {16'h0, delay_reg};
			default:        prdata = 32'h0;
		endcase
	end
	always_comb begin
		state_next  = state_reg;
		status_next = status_reg;
		cnt_next    = cnt_reg;
		case (state_reg)
			BCT_IDLE: begin
				if (start_w) begin
					state_next = BCT_ADDR;
					status_next = 6'h01;
				end
			end
			BCT_ADDR: begin
				if (resp_idle)
					state_next = BCT_STRB;
			end
			BCT_STRB: state_next = BCT_WAIT;
			BCT_WAIT: begin
				if (resp_any) begin
					state_next = BCT_END;
					status_next[BCT_ST_ACK]   = ack_hit;
					status_next[BCT_ST_BERR]  = berr_hit;
					status_next[BCT_ST_RETRY] = retry_hit && !ack_hit && !berr_hit;
				end
			end
			BCT_END: begin
				if (dtack_s && berr_s && retry_s) begin
					if (status_reg[BCT_ST_RETRY]) begin
						state_next = BCT_REL;
						status_next[BCT_ST_RELBUS] = 1'b1;
					end else begin
						state_next = BCT_IDLE;
						status_next[BCT_ST_BUSY] = 1'b0;
						status_next[BCT_ST_SIGOK] = sig_ok;
					end
				end
			end
			BCT_REL: begin
				cnt_next = delay_reg;
				state_next = other_req ? BCT_BACK : BCT_IDLE;
				if (!other_req)
					status_next[BCT_ST_BUSY] = 1'b0;
			end
			BCT_BACK: begin
				cnt_next = cnt_reg - 16'h0001;
				if (cnt_reg == 16'h0000) begin
					state_next = BCT_IDLE;
					status_next[BCT_ST_BUSY] = 1'b0;
				end
			end
			default: state_next = BCT_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= BCT_IDLE;
			status_reg <= 6'h00;
			cnt_reg    <= 16'h0000;
		end else begin
			state_reg  <= state_next;
			status_reg <= status_next;
			cnt_reg    <= cnt_next;
		end
	end
	// Registers frozen while a cycle runs so bus lines stay stable
	wire cfg_ok = wr_acc && state_reg == BCT_IDLE;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg  <= 3'h0;
			addr_reg  <= '0;
			wdata_reg <= 8'h00;
			delay_reg <= BCT_DELAY_RST;
		end else if (cfg_ok) begin
			if (paddr == BCT_CTRL_OFS)
				ctrl_reg <= {pwdata[BCT_CTRL_RTYEN], pwdata[BCT_CTRL_WRITE], 1'b0};
			if (paddr == BCT_ADDR_OFS)
				addr_reg <= pwdata[AW-1:0];
			if (paddr == BCT_WDATA_OFS)
				wdata_reg <= pwdata[7:0];
			if (paddr == BCT_DELAY_OFS)
				delay_reg <= pwdata[15:0];
		end
	end
	// Latch read byte at the acknowledge, before strobes rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rdata_reg <= 8'h00;
		else if (state_reg == BCT_WAIT && resp_any && !is_wr && ack_hit)
			rdata_reg <= data_s;
	end
	wire in_cyc  = state_reg == BCT_ADDR || state_reg == BCT_STRB
		|| state_reg == BCT_WAIT;
	wire ds_on   = state_reg == BCT_STRB || state_reg == BCT_WAIT;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			as_n     <= 1'b1;
			ds_n     <= 1'b1;
			write_n  <= 1'b1;
			data_oe  <= 1'b0;
			data_out <= 8'h00;
			bus_addr <= '0;
			bus_busy <= 1'b0;
		end else begin
			as_n     <= !(in_cyc && state_next != BCT_END);
			// Data strobe at least one cycle behind address strobe
			ds_n     <= !(ds_on && state_next != BCT_END);
			write_n  <= !(is_wr && in_cyc);
			data_oe  <= is_wr && in_cyc && state_next != BCT_END
				&& (state_reg != BCT_ADDR || resp_idle);
			data_out <= wdata_reg;
			bus_addr <= addr_reg;
			bus_busy <= state_next != BCT_IDLE && state_next != BCT_BACK
				&& state_next != BCT_REL;
		end
	end
	// Assertions
	strobe_order_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ds_n |-> !as_n) else $error("data strobe low without address strobe");
	ds_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(ds_n) |-> $past(dtack_s) && $past(berr_s))
		else $error("data strobe fell with response low");
	wr_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(data_oe) |-> $past(resp_idle))
		else $error("write data driven with response low");
	retry_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == BCT_WAIT && retry_hit |=> ##1 as_n && ds_n)
		else $error("retry did not end cycle");
	resp_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == BCT_WAIT && (ack_hit || berr_hit) |=> ##1 as_n && ds_n)
		else $error("response did not raise strobes");
	no_rtry_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == BCT_WAIT && !ctrl_reg[BCT_CTRL_RTYEN] && !retry_s
		&& dtack_s && berr_s |=> state_reg == BCT_WAIT)
		else $error("retry honoured while disabled");
	rel_bus_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == BCT_REL |=> !bus_busy)
		else $error("bus not released after retry");
	backoff_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == BCT_REL && other_req |=> state_reg == BCT_BACK)
		else $error("no back-off with other requests");
	rd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(rdata_reg) |-> $past(!ds_n) && $past(ack_hit))
		else $error("read byte taken outside strobe");
	cov_ack_c: cover property (@(posedge pclk) state_reg == BCT_WAIT && ack_hit);
	cov_berr_c: cover property (@(posedge pclk) state_reg == BCT_WAIT && berr_hit);
	cov_rtry_c: cover property (@(posedge pclk) state_reg == BCT_BACK);
	cov_sig_c: cover property (@(posedge pclk) status_reg[BCT_ST_SIGOK]);
endmodule : bct_master
`default_nettype wire

/* File: hw/bct_pkg.sv */
// Purpose: Shared constants for the bus cycle master controller
// Assumes: 200 MHz pclk, APB command registers, byte-wide ROM reads
// Notes:   Register offsets below are word byte addresses on APB
package bct_pkg;
	// APB register byte addresses
	localparam logic [7:0] BCT_CTRL_OFS   = 8'h00;
	localparam logic [7:0] BCT_ADDR_OFS   = 8'h04;
	localparam logic [7:0] BCT_WDATA_OFS  = 8'h08;
	localparam logic [7:0] BCT_RDATA_OFS  = 8'h0C;
	localparam logic [7:0] BCT_STATUS_OFS = 8'h10;
	localparam logic [7:0] BCT_DELAY_OFS  = 8'h14;
	// Control fields
	localparam int BCT_CTRL_START = 0;
	localparam int BCT_CTRL_WRITE = 1;
	localparam int BCT_CTRL_RTYEN = 2;
	// Status fields
	localparam int BCT_ST_BUSY  = 0;
	localparam int BCT_ST_ACK   = 1;
	localparam int BCT_ST_BERR  = 2;
	localparam int BCT_ST_RETRY = 3;
	localparam int BCT_ST_RELBUS = 4;
	localparam int BCT_ST_SIGOK = 5;
	// Configuration ROM layout
	localparam logic [7:0] BCT_ROM_SIG_OFS   = 8'h23;
	localparam logic [7:0] BCT_ROM_SIG_VAL   = 8'h52;
	localparam logic [7:0] BCT_ROM_MAKER_OFS = 8'h27;
	localparam logic [7:0] BCT_ROM_BOARD_OFS = 8'h33;
	localparam logic [7:0] BCT_ROM_REV_OFS   = 8'h43;
	localparam logic [7:0] BCT_ROM_PTR_OFS   = 8'h53;
	localparam logic [7:0] BCT_ROM_PROG_OFS  = 8'h7F;
	localparam logic [7:0] BCT_PROG_FORBID   = 8'hFF;
	localparam logic [7:0] BCT_PROG_UNUSED   = 8'h00;
	// Default retry back-off in cycles
	localparam logic [15:0] BCT_DELAY_RST = 16'h0010;
	typedef enum logic [2:0] {
		BCT_IDLE  = 3'b000,
		BCT_ADDR  = 3'b001,
		BCT_STRB  = 3'b011,
		BCT_WAIT  = 3'b010,
		BCT_END   = 3'b110,
		BCT_REL   = 3'b111,
		BCT_BACK  = 3'b101
	} bct_state_t;
endpackage : bct_pkg

/* File: hw/bct_sync.sv */
// Purpose: Two-flop synchroniser for bus pin inputs
// Assumes: Input is asynchronous to pclk
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module bct_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,    // clock
	input  wire logic         presetn, // async reset
	input  wire logic [W-1:0] d,       // async in
	input  wire logic [W-1:0] rst_val, // unused; q shows all ones out of reset
	output logic      [W-1:0] q        // synchronised
);
	logic [W-1:0] s1_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= '1;
			q      <= '1;
		end else begin
			s1_reg <= d;
			q      <= s1_reg;
		end
	end
	// rst_val kept for pins idle high; callers pass all ones for both the active-low response lines and the data lines
	logic unused_w;
	assign unused_w = &rst_val;
endmodule : bct_sync
`default_nettype wire

/* File: test/bct_slave_model.sv */
// Purpose: Slave device model answering the bus master
// Assumes: Response lines pulled up; one bus cycle at a time
// Notes:   mode 0 ack, 1 bus error, 2 busy retry, 3 deadlock retry
`timescale 1ns/1ps
`default_nettype none
module bct_slave_model (
	input  wire logic       pclk,    // timing reference
	input  wire logic       as_n,    // address strobe
	input  wire logic       ds_n,    // data strobe
	input  wire logic       write_n, // low for write
	input  wire logic [7:0] addr,    // low address lines
	input  wire logic [7:0] wr_d,    // bus data seen
	input  wire logic [1:0] mode,    // answer to give
	output logic            dtack_n, // acknowledge
	output logic            berr_n,  // bus error
	output logic            retry_n, // retry
	output logic      [7:0] rd_d,    // read data driven
	output logic      [7:0] got_d    // last byte written
);
	int n;
	function automatic logic [7:0] rom(input logic [7:0] a);
		case (a)
			8'h23: return 8'h52;
			8'h27: return 8'h0A;
			8'h2B: return 8'h0B;
			8'h2F: return 8'h0C;
			8'h53, 8'h57, 8'h5B: return 8'h00;
			8'h7F: return 8'h01;
			default: return 8'hFF;
		endcase
	endfunction : rom
	initial begin
		dtack_n = 1'b1;
		berr_n = 1'b1;
		retry_n = 1'b1;
		rd_d = 8'hA5;
		got_d = 8'h00;
		forever begin
			@(posedge pclk);
			if (!as_n && !ds_n) begin
				repeat (2) @(posedge pclk);
				if (!write_n)
					got_d <= wr_d;
				if (mode[1]) begin
					retry_n <= 1'b0;
					n = 0;
					while (!ds_n && n < 6) begin
						@(posedge pclk);
						n++;
					end
				end
				if (!ds_n) begin
					if (write_n)
						rd_d <= rom(addr);
					if (mode[0])
						berr_n <= 1'b0;
					else
						dtack_n <= 1'b0;
				end
				while (!ds_n)
					@(posedge pclk);
				// Released lines must not keep the old byte
				rd_d <= ~rd_d;
				@(posedge pclk);
				retry_n <= 1'b1;
				dtack_n <= 1'b1;
				berr_n <= 1'b1;
			end
		end
	end
endmodule : bct_slave_model
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the bus cycle master
// Assumes: Slave model on the pins, APB from the bench
// Notes:   All answer modes crossed with retry enable and direction
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	error_cnt++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_top;
	import bct_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        other_req = 0, pready, pslverr, as_n, ds_n, write_n;
	logic        data_oe, dtack_n, berr_n, retry_n, bus_busy;
	logic [7:0]  paddr = 0, data_out, rd_d, got_d, bus_d;
	logic [31:0] pwdata = 0, prdata;
	logic [23:0] bus_addr;
	logic [1:0]  mode = 0;
	int          error_cnt = 0, check_count = 0;
	logic [31:0] r;
	logic        e;
	always #2.5 pclk = ~pclk;
	assign bus_d = data_oe ? data_out : rd_d;
	bct_master dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_addr(bus_addr), .as_n(as_n), .ds_n(ds_n), .write_n(write_n),
		.data_in(bus_d), .data_out(data_out), .data_oe(data_oe),
		.dtack_n(dtack_n), .berr_n(berr_n), .retry_n(retry_n),
		.other_req(other_req), .bus_busy(bus_busy));
	bct_slave_model slv (.pclk(pclk), .as_n(as_n), .ds_n(ds_n),
		.write_n(write_n), .addr(bus_addr[7:0]), .wr_d(bus_d), .mode(mode),
		.dtack_n(dtack_n), .berr_n(berr_n), .retry_n(retry_n), .rd_d(rd_d),
		.got_d(got_d));
	always @(negedge ds_n)
		if (presetn) `CHK("strobe order", 3'b011, {as_n, dtack_n, berr_n})
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			error_cnt++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic run(input logic [1:0] m, input logic en, input logic w,
		input logic [7:0] a);
		int n;
		logic orq, ret, ack;
		logic [7:0] wd, x;
		orq = 1'($urandom % 2);
		wd = 8'($urandom);
		case (a)
			8'h23: x = 8'h52;
			8'h27: x = 8'h0A;
			8'h2B: x = 8'h0B;
			8'h2F: x = 8'h0C;
			8'h53, 8'h57, 8'h5B: x = 8'h00;
			8'h7F: x = 8'h01;
			default: x = 8'hFF;
		endcase
		ret = m[1] && en;
		ack = !ret && !m[0];
		mode <= m;
		other_req <= orq;
		apb(1'b1, BCT_ADDR_OFS, 32'(a));
		apb(1'b1, BCT_WDATA_OFS, 32'(wd));
		apb(1'b1, BCT_CTRL_OFS, {29'h0, en, w, 1'b1});
		n = 0;
		do begin
			apb(1'b0, BCT_STATUS_OFS, 32'h0);
			n++;
		end while (r[BCT_ST_BUSY] !== 1'b0 && n < 200);
		if (n >= 200)
			error_cnt++;
		`CHK("status", {ret, !ret && m[0], ack}, r[3:1])
		`CHK("bus held", 1'b0, bus_busy)
		if (ret && orq)
			`CHK("bus release", 1'b1, r[BCT_ST_RELBUS])
		if (ack && w)
			`CHK("written", wd, got_d)
		if (ack && !w) begin
			`CHK("marker", x == 8'h52, r[BCT_ST_SIGOK])
			apb(1'b0, BCT_RDATA_OFS, 32'h0);
			`CHK("rdata", x, r[7:0])
		end
	endtask : run
	initial begin
		repeat (100000) @(posedge pclk);
		error_cnt++;
		close_out;
	end
	initial begin
		void'($urandom(88));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, BCT_DELAY_OFS, 32'h0);
		`CHK("delay reset", 32'(BCT_DELAY_RST), r)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 1'b1, e)
		apb(1'b1, BCT_DELAY_OFS, 32'h3);
		run(2'd0, 1'b0, 1'b0, 8'h23);
		run(2'd0, 1'b1, 1'b0, 8'h7F);
		for (int i = 0; i < 16; i++)
			run(i[1:0], i[2], i[3], 8'h20 + 8'($urandom % 96));
		close_out;
	end
endmodule : tb_top
`default_nettype wire
